/* File: logic/svlch_consts.svh */
// Constants of the servo link command handshake: offsets, fields, codes.
// Assumes a 32-bit APB master with byte addresses on paddr[7:0].
// Function
// - request bit high selects automatic, low manual
// - pause edge in automatic holds remaining distance
// - second pause edge while held resumes motion
// - start requests ignored while temporarily stopped
// - leaving automatic while held discards remaining distance
// - pause ignored during home return or jog
// - monitor request loads replies, raises monitor valid
// - replies refresh every cycle while valid
// - single layout: monitor one into word zero
// - single layout: monitor two, answer code follow
// - dual layout: monitor one low half word zero
// - dual layout: high half word one, answer two
// - dual layout: monitor two low half word five
// - dual layout: monitor two high half word six
// - instruction request runs code in command word two
// - on finish answer to word two, set done
`ifndef SVLCH_CONSTS_SVH
`define SVLCH_CONSTS_SVH
`define SVLCH_OFS_CTRL   8'h00
`define SVLCH_OFS_CMD0   8'h04
`define SVLCH_OFS_CMD1   8'h08
`define SVLCH_OFS_CMD2   8'h0C
`define SVLCH_OFS_STAT   8'h10
`define SVLCH_OFS_RPL0   8'h20
`define SVLCH_RPL_WORDS  7
`define SVLCH_B_AUTO     0
`define SVLCH_B_PAUSE    1
`define SVLCH_B_FWD      2
`define SVLCH_B_REV      3
`define SVLCH_B_MONREQ   4
`define SVLCH_B_INSREQ   5
`define SVLCH_B_DUAL     6
`define SVLCH_CTRL_W     7
`define SVLCH_ANS_OK     16'h0000
`define SVLCH_ANS_ERR    16'h0001
`define SVLCH_SEL_LIMIT  16'h0040
`endif

/* File: logic/svlch_pkg.sv */
// Types of the servo link command handshake.
// Assumes nothing beyond the constants header.
`default_nettype none
package svlch_pkg;
    typedef enum logic [1:0] {
        ST_MANUAL = 2'b00,
        ST_AUTO   = 2'b01,
        ST_HOLD   = 2'b10
    } svlch_state_t;
endpackage : svlch_pkg
`default_nettype wire

/* File: logic/svlch_core.sv */
// Command interpreter: APB registers, mode and pause control,
// monitor and instruction handshakes with reply words.
// Assumes motion core and monitor sources run on pclk.
`include "svlch_consts.svh"
`default_nettype none
module svlch_core (
    input  wire logic        pclk,            // Bus clock 100 MHz
    input  wire logic        presetn,         // Async reset, low
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB enable
    input  wire logic        pwrite,          // APB direction
    input  wire logic [7:0]  paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error
    input  wire logic        move_active,     // Positioning running
    input  wire logic        home_jog_active, // Home return or jog
    input  wire logic [31:0] mon_val1,        // Value for selector 1
    input  wire logic [31:0] mon_val2,        // Value for selector 2
    input  wire logic        instr_finish,    // Instruction finished
    input  wire logic [15:0] instr_answer,    // Its answer code
    output logic             auto_mode,       // Automatic mode
    output logic             hold,            // Temporary stop
    output logic             start_fwd,       // Forward start pulse
    output logic             start_rev,       // Reverse start pulse
    output logic             discard,         // Erase remaining pulse
    output logic             resume,          // Restart pulse
    output logic      [15:0] mon_sel1,        // Monitor 1 selector
    output logic      [15:0] mon_sel2,        // Monitor 2 selector
    output logic      [15:0] instr_code,      // Instruction code
    output logic             instr_start,     // Instruction pulse
    output logic             monitor_valid,   // Monitor flag
    output logic             instruction_done // Instruction flag
);
    logic [`SVLCH_CTRL_W-1:0] ctrl_r, ctrl_nxt, prev_r;
    logic [15:0]  cmd_r [3];
    logic [15:0]  cmd_nxt [3];
    logic [31:0]  prdata_r, prdata_nxt;
    logic         pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [`SVLCH_CTRL_W-1:0] rise;
    logic         wr_acc, dual;

    assign wr_acc = psel & penable & pready_r & pwrite;
    assign rise   = ctrl_r & ~prev_r;
    assign dual   = ctrl_r[`SVLCH_B_DUAL];

    // Replies and status are read below; decode at setup phase.
    logic [15:0]  rpl_r [`SVLCH_RPL_WORDS];
    logic [15:0]  rpl_nxt [`SVLCH_RPL_WORDS];
    logic [4:0]   stat;
    svlch_pkg::svlch_state_t st_r, st_nxt;
    logic         mv_r, mv_nxt, done_r, done_nxt, busy_r, busy_nxt;

    always_comb begin
        logic [3:0] idx;
        idx         = 4'h0;
        ctrl_nxt    = ctrl_r;
        cmd_nxt     = cmd_r;
        prdata_nxt  = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        pready_nxt  = psel & ~penable;
        if (psel & ~penable) begin
            idx = paddr[5:2] - 4'h8;
            unique case (paddr)
                `SVLCH_OFS_CTRL: prdata_nxt = {25'h0, ctrl_r};
                `SVLCH_OFS_CMD0: prdata_nxt = {16'h0, cmd_r[0]};
                `SVLCH_OFS_CMD1: prdata_nxt = {16'h0, cmd_r[1]};
                `SVLCH_OFS_CMD2: prdata_nxt = {16'h0, cmd_r[2]};
                `SVLCH_OFS_STAT: prdata_nxt = {27'h0, stat};
                default: begin
                    // Upper address bits must be zero, or the access gets an error
                    if (paddr >= `SVLCH_OFS_RPL0 && paddr[1:0] == 2'h0
                        && paddr[7:6] == 2'h0
                        && idx < 4'(`SVLCH_RPL_WORDS) && !pwrite)
                        prdata_nxt = {16'h0, rpl_r[idx[2:0]]};
                    else
                        pslverr_nxt = 1'b1;
                end
            endcase
            if (pwrite && paddr == `SVLCH_OFS_STAT)
                pslverr_nxt = 1'b1;
        end
        if (wr_acc) begin
            unique case (paddr)
                `SVLCH_OFS_CTRL:
                    ctrl_nxt = pwdata[`SVLCH_CTRL_W-1:0];
                `SVLCH_OFS_CMD0: cmd_nxt[0] = pwdata[15:0];
                `SVLCH_OFS_CMD1: cmd_nxt[1] = pwdata[15:0];
                `SVLCH_OFS_CMD2: cmd_nxt[2] = pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r    <= '0;
            prev_r    <= '0;
            cmd_r     <= '{16'h0000, 16'h0000, 16'h0000};
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            prev_r    <= ctrl_r;
            cmd_r     <= cmd_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Mode and temporary stop
    logic fwd_nxt, rev_nxt, disc_nxt, res_nxt;
    logic fwd_r, rev_r, disc_r, res_r;
    logic auto_r, hold_r, auto_nxt, hold_nxt;
    always_comb begin
        st_nxt   = st_r;
        disc_nxt = 1'b0;
        res_nxt  = 1'b0;
        unique case (st_r)
            svlch_pkg::ST_MANUAL:
                if (ctrl_r[`SVLCH_B_AUTO])
                    st_nxt = svlch_pkg::ST_AUTO;
            svlch_pkg::ST_AUTO:
                if (!ctrl_r[`SVLCH_B_AUTO])
                    st_nxt = svlch_pkg::ST_MANUAL;
                else if (rise[`SVLCH_B_PAUSE] && !home_jog_active
                         && move_active)
                    st_nxt = svlch_pkg::ST_HOLD;
            svlch_pkg::ST_HOLD:
                if (!ctrl_r[`SVLCH_B_AUTO]) begin
                    st_nxt   = svlch_pkg::ST_MANUAL;
                    disc_nxt = 1'b1;
                end else if (rise[`SVLCH_B_PAUSE]
                             && !home_jog_active) begin
                    st_nxt  = svlch_pkg::ST_AUTO;
                    res_nxt = 1'b1;
                end
            default: st_nxt = svlch_pkg::ST_MANUAL;
        endcase
        // Starts are dropped, not deferred, during a hold
        fwd_nxt = rise[`SVLCH_B_FWD] && st_r != svlch_pkg::ST_HOLD;
        rev_nxt = rise[`SVLCH_B_REV] && st_r != svlch_pkg::ST_HOLD;
        // Flags taken from the next state, so outputs leave a flop
        auto_nxt = st_nxt != svlch_pkg::ST_MANUAL;
        hold_nxt = st_nxt == svlch_pkg::ST_HOLD;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= svlch_pkg::ST_MANUAL;
            fwd_r  <= 1'b0;
            rev_r  <= 1'b0;
            disc_r <= 1'b0;
            res_r  <= 1'b0;
            auto_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            fwd_r  <= fwd_nxt;
            rev_r  <= rev_nxt;
            disc_r <= disc_nxt;
            res_r  <= res_nxt;
            auto_r <= auto_nxt;
            hold_r <= hold_nxt;
        end
    end

    // Monitor and instruction handshakes
    logic [15:0] sel2_r, sel2_nxt, mon_ans;
    logic        ist_r, ist_nxt;
    always_comb begin
        sel2_nxt = dual ? cmd_r[2] : cmd_r[1];
        mon_ans  = (cmd_r[0] >= `SVLCH_SEL_LIMIT
                    || sel2_r >= `SVLCH_SEL_LIMIT)
                   ? `SVLCH_ANS_ERR : `SVLCH_ANS_OK;
        rpl_nxt  = rpl_r;
        mv_nxt   = mv_r;
        if (rise[`SVLCH_B_MONREQ]) mv_nxt = 1'b1;
        else if (!ctrl_r[`SVLCH_B_MONREQ]) mv_nxt = 1'b0;
        if (mv_nxt) begin
            if (!dual) begin
                rpl_nxt[0] = mon_val1[15:0];
                rpl_nxt[1] = mon_val2[15:0];
            end else begin
                rpl_nxt[0] = mon_val1[15:0];
                rpl_nxt[1] = mon_val1[31:16];
                rpl_nxt[5] = mon_val2[15:0];
                rpl_nxt[6] = mon_val2[31:16];
            end
            rpl_nxt[2] = mon_ans;
        end
        ist_nxt  = rise[`SVLCH_B_INSREQ] && !busy_r;
        busy_nxt = busy_r | ist_nxt;
        done_nxt = done_r;
        if (!ctrl_r[`SVLCH_B_INSREQ]) done_nxt = 1'b0;
        // Finish outranks the clear and the monitor answer
        if (busy_r && instr_finish) begin
            busy_nxt   = 1'b0;
            done_nxt   = 1'b1;
            rpl_nxt[2] = instr_answer;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rpl_r  <= '{default: 16'h0000};
            mv_r   <= 1'b0;
            done_r <= 1'b0;
            busy_r <= 1'b0;
            ist_r  <= 1'b0;
            sel2_r <= 16'h0000;
        end else begin
            rpl_r  <= rpl_nxt;
            mv_r   <= mv_nxt;
            done_r <= done_nxt;
            busy_r <= busy_nxt;
            ist_r  <= ist_nxt;
            sel2_r <= sel2_nxt;
        end
    end

    assign stat = {busy_r, done_r, mv_r, hold_r, auto_r};

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign auto_mode        = auto_r;
    assign hold             = hold_r;
    assign start_fwd        = fwd_r;
    assign start_rev        = rev_r;
    assign discard          = disc_r;
    assign resume           = res_r;
    assign mon_sel1         = cmd_r[0];
    assign mon_sel2         = sel2_r;
    assign instr_code       = cmd_r[2];
    assign instr_start      = ist_r;
    assign monitor_valid    = mv_r;
    assign instruction_done = done_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_auto_follows: assert property (
        ctrl_r[`SVLCH_B_AUTO] |=> auto_mode)
        else $error("auto select not followed");
    chk_manual_follows: assert property (
        !ctrl_r[`SVLCH_B_AUTO] |=> !auto_mode)
        else $error("manual select not followed");
    chk_pause_holds: assert property (
        st_r == svlch_pkg::ST_AUTO && ctrl_r[`SVLCH_B_AUTO]
        && move_active && !home_jog_active && rise[`SVLCH_B_PAUSE]
        |=> hold)
        else $error("pause did not hold");
    chk_restart_pulse: assert property (
        hold && ctrl_r[`SVLCH_B_AUTO] && !home_jog_active
        && rise[`SVLCH_B_PAUSE] |=> resume && !hold)
        else $error("restart missing");
    chk_start_blocked: assert property (
        hold |=> !start_fwd && !start_rev)
        else $error("start leaked during hold");
    chk_discard_once: assert property (
        hold && !ctrl_r[`SVLCH_B_AUTO] |=> discard ##1 !discard)
        else $error("discard not pulsed");
    chk_jog_ignores: assert property (
        home_jog_active && ctrl_r[`SVLCH_B_AUTO] |=> $stable(hold))
        else $error("pause acted during jog");
    chk_monitor_raise: assert property (
        rise[`SVLCH_B_MONREQ] |=> monitor_valid
        && rpl_r[0] == $past(mon_val1[15:0]))
        else $error("monitor not loaded");
    chk_monitor_refresh: assert property (
        monitor_valid && $past(monitor_valid) && $past(dual) |->
        rpl_r[6] == $past(mon_val2[31:16]))
        else $error("monitor word six stale");
    chk_done_answer: assert property (
        busy_r && instr_finish |=> instruction_done
        && rpl_r[2] == $past(instr_answer))
        else $error("instruction answer missing");
    chk_done_clear: assert property (
        !ctrl_r[`SVLCH_B_INSREQ] && !(busy_r && instr_finish)
        |=> !instruction_done)
        else $error("done flag not cleared");
    chk_monitor_drop: assert property (
        !ctrl_r[`SVLCH_B_MONREQ] |=> !monitor_valid)
        else $error("monitor flag not cleared");
    chk_instr_start: assert property (
        rise[`SVLCH_B_INSREQ] && !busy_r |=> instr_start)
        else $error("instruction not started");
    chk_single_second: assert property (
        monitor_valid && !$past(dual) |->
        rpl_r[1] == $past(mon_val2[15:0]))
        else $error("monitor word one stale");
    chk_dual_upper: assert property (
        monitor_valid && $past(dual) |->
        rpl_r[1] == $past(mon_val1[31:16]))
        else $error("monitor word one upper half wrong");
    chk_dual_second: assert property (
        monitor_valid && $past(dual) |->
        rpl_r[5] == $past(mon_val2[15:0]))
        else $error("monitor word five stale");

    cov_pause_resume: cover property (hold ##[1:50] resume);
    cov_discard: cover property (discard);
    cov_dual_monitor: cover property (monitor_valid && dual);
    cov_instruction: cover property (instr_start ##[1:50] instruction_done);
endmodule : svlch_core
`default_nettype wire

/* File: bench/svlch_far.sv */
// Model of the motion and monitor side facing the command block.
// Assumes it shares pclk and presetn with the block.
`default_nettype none
module svlch_far #(
    parameter int LAT = 4                  // Instruction run time
) (
    input  wire logic        pclk,         // Clock
    input  wire logic        presetn,      // Async reset, low
    input  wire logic [15:0] mon_sel1,     // Selector 1
    input  wire logic [15:0] mon_sel2,     // Selector 2
    input  wire logic        instr_start,  // Instruction pulse
    input  wire logic [15:0] instr_code,   // Instruction code
    output logic      [31:0] mon_val1,     // Value 1
    output logic      [31:0] mon_val2,     // Value 2
    output logic             instr_finish, // Finish pulse
    output logic      [15:0] instr_answer  // Answer code
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_r;
    // Halves differ so a swapped half shows in the replies
    assign mon_val1 = {~mon_sel1, mon_sel1};
    assign mon_val2 = {~mon_sel2, mon_sel2};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 0;
            instr_finish <= 1'b0;
            instr_answer <= 16'h0000;
        end else begin
            instr_finish <= 1'b0;
            // Answer is only valid with finish; it churns otherwise
            instr_answer <= ~instr_answer;
            if (instr_start) begin
                cnt_r <= LAT;
            end else if (cnt_r > 0) begin
                cnt_r <= cnt_r - 1;
                if (cnt_r == 1) begin
                    instr_finish <= 1'b1;
                    instr_answer <= instr_code + 16'h0001;
                end
            end
        end
    end
endmodule : svlch_far
`default_nettype wire

/* File: bench/svlch_core_tb.sv */
// Self-checking bench: APB master tasks drive the command block.
// Assumes the far-side model answers instructions after LAT cycles.
`include "svlch_consts.svh"
`default_nettype none
module svlch_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        move_active, home_jog_active, instr_finish, auto_mode;
    logic        hold, start_fwd, start_rev, discard, resume, instr_start;
    logic        monitor_valid, instruction_done, err;
    logic [7:0]  paddr;
    logic [15:0] mon_sel1, mon_sel2, instr_code, instr_answer;
    logic [31:0] pwdata, prdata, rd, mon_val1, mon_val2;
    int          miscompares, num_checks, cycles, n_fwd, n_res, n_dis, n_rev;

    svlch_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .move_active,
        .home_jog_active, .mon_val1, .mon_val2, .instr_finish,
        .instr_answer, .auto_mode, .hold, .start_fwd, .start_rev,
        .discard, .resume, .mon_sel1, .mon_sel2, .instr_code,
        .instr_start, .monitor_valid, .instruction_done);
    svlch_far #(.LAT(4)) far (.pclk, .presetn, .mon_sel1, .mon_sel2,
        .instr_start, .instr_code, .mon_val1, .mon_val2, .instr_finish,
        .instr_answer);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Pulse counters, and a ceiling well above the expected run
    always @(posedge pclk) begin
        cycles++;
        if (start_fwd === 1'b1) n_fwd++;
        if (start_rev === 1'b1) n_rev++;
        if (resume === 1'b1) n_res++;
        if (discard === 1'b1) n_dis++;
        if (cycles == 4000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // One idle cycle between transfers keeps each signal single-driven
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic step(int n);
        repeat (n) @(posedge pclk);
    endtask : step

    task automatic ctl(logic [31:0] d);
        xfer(1'b1, `SVLCH_OFS_CTRL, d);
    endtask : ctl

    task automatic rpl(int i, logic [31:0] e);
        xfer(1'b0, `SVLCH_OFS_RPL0 + 8'(4 * i), 32'h0);
        check("reply", rd, e);
    endtask : rpl

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        move_active = 1'b1;
        home_jog_active = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        step(1);
        xfer(1'b0, `SVLCH_OFS_STAT, 32'h0);
        check("stat", rd, 32'h0);
        ctl(32'h1);
        step(4);
        check("auto", auto_mode, 1);
        ctl(32'h3);
        step(4);
        check("hold", hold, 1);
        ctl(32'hF);
        step(4);
        check("fwd", n_fwd, 0);
        check("rev", n_rev, 0);
        ctl(32'h1);
        ctl(32'h3);
        step(4);
        check("hold", hold, 0);
        check("resume", n_res, 1);
        ctl(32'h5);
        step(4);
        check("fwd", n_fwd, 1);
        ctl(32'h9);
        step(4);
        check("rev", n_rev, 1);
        ctl(32'h1);
        ctl(32'h3);
        ctl(32'h2);
        step(4);
        check("discard", n_dis, 1);
        check("auto", auto_mode, 0);
        home_jog_active <= 1'b1;
        ctl(32'h1);
        ctl(32'h3);
        step(4);
        check("hold", hold, 0);
        home_jog_active <= 1'b0;
        ctl(32'h0);
        xfer(1'b1, `SVLCH_OFS_CMD0, 32'h12);
        xfer(1'b1, `SVLCH_OFS_CMD1, 32'h34);
        ctl(32'h10);
        step(4);
        check("valid", monitor_valid, 1);
        rpl(0, 32'h12);
        rpl(1, 32'h34);
        rpl(2, `SVLCH_ANS_OK);
        xfer(1'b1, `SVLCH_OFS_CMD0, 32'h41);
        step(4);
        rpl(0, 32'h41);
        rpl(2, `SVLCH_ANS_ERR);
        xfer(1'b1, `SVLCH_OFS_CMD0, 32'h12);
        xfer(1'b1, `SVLCH_OFS_CMD2, 32'h21);
        ctl(32'h50);
        step(4);
        rpl(0, 32'h12);
        rpl(1, 32'hFFED);
        rpl(2, `SVLCH_ANS_OK);
        rpl(5, 32'h21);
        rpl(6, 32'hFFDE);
        ctl(32'h40);
        step(4);
        check("valid", monitor_valid, 0);
        xfer(1'b1, `SVLCH_OFS_CMD2, 32'h7);
        ctl(32'h20);
        for (int i = 0; i < 30 && instruction_done !== 1'b1; i++) step(1);
        check("done", instruction_done, 1);
        check("code", instr_code, 32'h7);
        rpl(2, 32'h8);
        ctl(32'h0);
        step(4);
        check("done", instruction_done, 0);
        xfer(1'b0, 8'h3C, 32'h0);
        check("unmapped", err, 1);
        xfer(1'b1, `SVLCH_OFS_STAT, 32'h1);
        check("ro", err, 1);
        wrap_up();
    end
endmodule : svlch_core_tb
`default_nettype wire
